// file: hdl/crc_unit.sv
`timescale 1ns/100ps
// Summary of operation
// - select bit 0 picks 32-bit, 1 picks 16-bit
// - init select: zeros when 0, ones when 1
// - init strobe write loads whole result preset
// - each input byte write outside a scan folds into result
// - result holds until init, port write, byte
// - pointer selects port byte, increments each access
// - 32-bit pointer maps four bytes, wraps
// - 16-bit pointer aliases bytes 00/10, 01/11
// - control write with auto enable starts scan
// - every sector scanned is 512 bytes
// - cpu stalled from scan start to last fold
// - control bits 7:5 read zero, ignore writes
// - 16-bit: xor high byte, shift left msb-first
// - 32-bit: xor low byte, reflected shift right
// - scan starts at start index times 512
module crc_unit (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // special-function register bus, same clock
   input wire crc_unit_pkg::sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // flash read port, one cycle latency
   output logic flash_rd,
   output logic [14:0] flash_addr,
   input wire logic [7:0] flash_rdata,
   // processor hold
   output logic cpu_stall
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic poly_width_select_ff;
   logic init_value_select_ff;
   logic [1:0] result_byte_pointer_ff;
   logic [7:0] crc_byte_input_ff;
   logic auto_flash_enable_ff;
   logic [4:0] start_sector_index_ff;
   logic [5:0] flash_sector_count_ff;
   logic [31:0] result_ff;
   crc_unit_pkg::scan_state_t scan_ff;
   logic [14:0] scan_addr_ff;
   logic [14:0] scan_left_ff;
   logic [7:0] sfr_rdata_ff;
   logic flash_rd_ff;
   logic cpu_stall_ff;

   ////////////////////////////////////////////////////////////////////////
   // decode
   wire wr_ctl = sfr_req.wr && sfr_req.addr == crc_unit_pkg::ADDR_CONTROL;
   wire wr_in = sfr_req.wr && sfr_req.addr == crc_unit_pkg::ADDR_BYTE_INPUT;
   wire wr_dat = sfr_req.wr && sfr_req.addr == crc_unit_pkg::ADDR_RESULT_DATA;
   wire rd_dat = sfr_req.rd && sfr_req.addr == crc_unit_pkg::ADDR_RESULT_DATA;
   wire wr_auto = sfr_req.wr &&
      sfr_req.addr == crc_unit_pkg::ADDR_AUTO_CONTROL;
   wire wr_cnt = sfr_req.wr &&
      sfr_req.addr == crc_unit_pkg::ADDR_SECTOR_COUNT;
   wire scan_busy = scan_ff != crc_unit_pkg::SCAN_IDLE;
   // bus is quiet while the cpu is held, so accesses during a scan are dropped
   wire bus_ok = !scan_busy;
   wire dat_access = bus_ok && (wr_dat || rd_dat);
   wire init_req = bus_ok && wr_ctl &&
      sfr_req.wdata[crc_unit_pkg::POS_INIT_STROBE];
   wire scan_start = bus_ok && wr_ctl && auto_flash_enable_ff;

   ////////////////////////////////////////////////////////////////////////
   // byte fold, shared by input writes and scan
   wire fold_in = bus_ok && wr_in;
   wire fold_scan = scan_ff == crc_unit_pkg::SCAN_FOLD;
   wire [7:0] fold_byte = fold_scan ? flash_rdata : sfr_req.wdata;

   // one stage per input bit, unrolled so a byte folds in one clock;
   // the 32-bit chain is the longest path of the block
   wire [8:0][15:0] chain16;
   wire [8:0][31:0] chain32;
   assign chain16[0] = result_ff[15:0] ^ {fold_byte, 8'h00};
   assign chain32[0] = result_ff ^ {24'h000000, fold_byte};
   for (genvar g = 0; g < 8; g++) begin : g_bit
      fold_step fold_step_inst (
         .in16(chain16[g]),
         .in32(chain32[g]),
         .out16(chain16[g + 1]),
         .out32(chain32[g + 1])
      );
   end
   wire [31:0] folded = poly_width_select_ff ?
      {16'h0000, chain16[8]} : chain32[8];

   // 16-bit mode ignores pointer bit 1
   wire [1:0] sel_byte = poly_width_select_ff ?
      {1'b0, result_byte_pointer_ff[0]} : result_byte_pointer_ff;
   wire [7:0] result_byte = result_ff[8*sel_byte +: 8];
   wire [31:0] wr_mask = 32'h000000FF << (8 * sel_byte);
   wire [31:0] ported = (result_ff & ~wr_mask) |
      ({24'h000000, sfr_req.wdata} << (8 * sel_byte));
   wire [31:0] init_value = sfr_req.wdata[crc_unit_pkg::POS_INIT_VAL] ?
      crc_unit_pkg::PRESET_ONES : crc_unit_pkg::PRESET_ZERO;

   logic [31:0] nxt_result;
   always_comb begin
      nxt_result = result_ff;
      if (fold_scan || fold_in) begin
         nxt_result = folded;
      end else if (init_req) begin
         // preset follows the select bit written in the same access
         nxt_result = init_value;
      end else if (bus_ok && wr_dat) begin
         nxt_result = ported;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flash scan sequencer
   wire [14:0] scan_base = 15'(start_sector_index_ff)
      << crc_unit_pkg::SECTOR_BITS;
   wire [14:0] scan_len = 15'(flash_sector_count_ff)
      << crc_unit_pkg::SECTOR_BITS;
   crc_unit_pkg::scan_state_t nxt_scan;
   always_comb begin
      case (scan_ff)
         crc_unit_pkg::SCAN_IDLE:
            nxt_scan = (scan_start && scan_len != 15'h0000) ?
               crc_unit_pkg::SCAN_REQ : crc_unit_pkg::SCAN_IDLE;
         crc_unit_pkg::SCAN_REQ: nxt_scan = crc_unit_pkg::SCAN_FOLD;
         crc_unit_pkg::SCAN_FOLD:
            nxt_scan = (scan_left_ff == 15'h0001) ?
               crc_unit_pkg::SCAN_IDLE : crc_unit_pkg::SCAN_REQ;
         default: nxt_scan = crc_unit_pkg::SCAN_IDLE;
      endcase
   end

   wire nxt_flash_rd = nxt_scan == crc_unit_pkg::SCAN_REQ;
   wire nxt_stall = nxt_scan != crc_unit_pkg::SCAN_IDLE;

   ////////////////////////////////////////////////////////////////////////
   // read data
   wire [7:0] ctl_read = {3'b000, poly_width_select_ff, 1'b0,
      init_value_select_ff, result_byte_pointer_ff};
   // completion flag reads 1: code never runs mid-scan
   wire [7:0] auto_read = {auto_flash_enable_ff, 2'b10,
      start_sector_index_ff};
   logic [7:0] nxt_rdata;
   always_comb begin
      case (sfr_req.addr)
         crc_unit_pkg::ADDR_CONTROL: nxt_rdata = ctl_read;
         crc_unit_pkg::ADDR_BYTE_INPUT: nxt_rdata = crc_byte_input_ff;
         crc_unit_pkg::ADDR_RESULT_DATA: nxt_rdata = result_byte;
         crc_unit_pkg::ADDR_AUTO_CONTROL: nxt_rdata = auto_read;
         crc_unit_pkg::ADDR_SECTOR_COUNT:
            nxt_rdata = {2'b00, flash_sector_count_ff};
         default: nxt_rdata = crc_unit_pkg::RESET_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state
   logic nxt_poly_width_select;
   logic nxt_init_value_select;
   logic [1:0] nxt_result_byte_pointer;
   always_comb begin
      nxt_poly_width_select = poly_width_select_ff;
      nxt_init_value_select = init_value_select_ff;
      nxt_result_byte_pointer = result_byte_pointer_ff;
      if (bus_ok && wr_ctl) begin
         // bits 7:5 have no storage, so they always read zero
         nxt_poly_width_select =
            sfr_req.wdata[crc_unit_pkg::POS_POLY_SEL];
         nxt_init_value_select =
            sfr_req.wdata[crc_unit_pkg::POS_INIT_VAL];
         nxt_result_byte_pointer = sfr_req.wdata[crc_unit_pkg::POS_PTR_HI:
            crc_unit_pkg::POS_PTR_LO];
      end else if (dat_access) begin
         // wraps from 11 to 00 by plain 2-bit overflow
         nxt_result_byte_pointer = result_byte_pointer_ff + 2'b01;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         poly_width_select_ff <= 1'b0;
         init_value_select_ff <= 1'b0;
         result_byte_pointer_ff <= 2'b00;
      end else begin
         poly_width_select_ff <= nxt_poly_width_select;
         init_value_select_ff <= nxt_init_value_select;
         result_byte_pointer_ff <= nxt_result_byte_pointer;
      end
   end

   logic [7:0] nxt_crc_byte_input;
   logic nxt_auto_flash_enable;
   logic [4:0] nxt_start_sector_index;
   logic [5:0] nxt_flash_sector_count;
   always_comb begin
      nxt_crc_byte_input = crc_byte_input_ff;
      nxt_auto_flash_enable = auto_flash_enable_ff;
      nxt_start_sector_index = start_sector_index_ff;
      nxt_flash_sector_count = flash_sector_count_ff;
      if (fold_in) begin
         nxt_crc_byte_input = sfr_req.wdata;
      end
      // writes while the cpu is held cannot occur, so they are dropped
      if (bus_ok && wr_auto) begin
         nxt_auto_flash_enable = sfr_req.wdata[crc_unit_pkg::POS_AUTO_EN];
         nxt_start_sector_index = sfr_req.wdata[4:0];
      end
      if (bus_ok && wr_cnt) begin
         nxt_flash_sector_count = sfr_req.wdata[5:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         crc_byte_input_ff <= crc_unit_pkg::RESET_BYTE;
         auto_flash_enable_ff <= 1'b0;
         start_sector_index_ff <= 5'h00;
         flash_sector_count_ff <= 6'h00;
      end else begin
         crc_byte_input_ff <= nxt_crc_byte_input;
         auto_flash_enable_ff <= nxt_auto_flash_enable;
         start_sector_index_ff <= nxt_start_sector_index;
         flash_sector_count_ff <= nxt_flash_sector_count;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         result_ff <= crc_unit_pkg::PRESET_ZERO;
      end else begin
         result_ff <= nxt_result;
      end
   end

   logic [14:0] nxt_scan_addr;
   logic [14:0] nxt_scan_left;
   always_comb begin
      nxt_scan_addr = scan_addr_ff;
      nxt_scan_left = scan_left_ff;
      if (scan_ff == crc_unit_pkg::SCAN_IDLE) begin
         // reload while idle so a start sees the latest index and count
         nxt_scan_addr = scan_base;
         nxt_scan_left = scan_len;
      end else if (fold_scan) begin
         nxt_scan_addr = scan_addr_ff + 15'h0001;
         nxt_scan_left = scan_left_ff - 15'h0001;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scan_ff <= crc_unit_pkg::SCAN_IDLE;
         scan_addr_ff <= 15'h0000;
         scan_left_ff <= 15'h0000;
      end else begin
         scan_ff <= nxt_scan;
         scan_addr_ff <= nxt_scan_addr;
         scan_left_ff <= nxt_scan_left;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_rdata_ff <= crc_unit_pkg::RESET_BYTE;
         flash_rd_ff <= 1'b0;
         cpu_stall_ff <= 1'b0;
      end else begin
         sfr_rdata_ff <= nxt_rdata;
         flash_rd_ff <= nxt_flash_rd;
         cpu_stall_ff <= nxt_stall;
      end
   end

   assign sfr_rdata = sfr_rdata_ff;
   assign flash_rd = flash_rd_ff;
   assign flash_addr = scan_addr_ff;
   assign cpu_stall = cpu_stall_ff;

endmodule : crc_unit

////////////////////////////////////////////////////////////////////////////
// one bit of the byte fold for both codes
module fold_step (
   // remainders before this bit
   input wire logic [15:0] in16,
   input wire logic [31:0] in32,
   // remainders after this bit
   output logic [15:0] out16,
   output logic [31:0] out32
);

   // 16-bit code runs msb-first, the reflected 32-bit code lsb-first
   wire [15:0] shl16 = {in16[14:0], 1'b0};
   wire [31:0] shr32 = {1'b0, in32[31:1]};

   assign out16 = in16[15] ?
      (shl16 ^ crc_unit_pkg::POLY16) : shl16;
   assign out32 = in32[0] ?
      (shr32 ^ crc_unit_pkg::POLY32_REFL) : shr32;

endmodule : fold_step

// file: hdl/crc_unit_pkg.sv
package crc_unit_pkg;
   // special-function register addresses
   localparam logic [7:0] ADDR_CONTROL = 8'hCE;
   localparam logic [7:0] ADDR_BYTE_INPUT = 8'hDD;
   localparam logic [7:0] ADDR_RESULT_DATA = 8'hDE;
   localparam logic [7:0] ADDR_AUTO_CONTROL = 8'hD2;
   localparam logic [7:0] ADDR_SECTOR_COUNT = 8'hD3;
   // control field positions
   localparam int POS_POLY_SEL = 4;
   localparam int POS_INIT_STROBE = 3;
   localparam int POS_INIT_VAL = 2;
   localparam int POS_PTR_HI = 1;
   localparam int POS_PTR_LO = 0;
   // auto control field positions
   localparam int POS_AUTO_EN = 7;
   localparam int POS_AUTO_DONE = 6;
   localparam int POS_START_HI = 4;
   localparam int POS_COUNT_HI = 5;
   // reset values and constants
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [31:0] PRESET_ZERO = 32'h00000000;
   localparam logic [31:0] PRESET_ONES = 32'hFFFFFFFF;
   localparam logic [15:0] POLY16 = 16'h1021;
   localparam logic [31:0] POLY32 = 32'h04C11DB7;
   localparam logic [31:0] POLY32_REFL = 32'hEDB88320;
   localparam int SECTOR_BITS = 9;
   localparam int FLASH_ADDR_W = 15;

   // register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef enum logic [1:0] {
      SCAN_IDLE = 2'b00,
      SCAN_REQ = 2'b01,
      SCAN_FOLD = 2'b10
   } scan_state_t;
endpackage : crc_unit_pkg

// file: tb/flash_model.sv
`timescale 1ns/100ps
module flash_model (
   // clock
   input wire logic clk,
   // flash read port
   input wire logic flash_rd,
   input wire logic [14:0] flash_addr,
   output logic [7:0] flash_rdata
);
   initial flash_rdata = 8'h00;
   // data valid one cycle only, then scrambled so stale bytes never pass
   always @(posedge clk) begin
      if (flash_rd)
         flash_rdata <= flash_addr[7:0] ^ flash_addr[14:7];
      else
         flash_rdata <= ~flash_rdata;
   end
endmodule : flash_model

// file: tb/crc_unit_sva.sv
`timescale 1ns/100ps
module crc_unit_sva (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register bus and flash port
   input wire crc_unit_pkg::sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic flash_rd,
   input wire logic [14:0] flash_addr,
   input wire logic [7:0] flash_rdata,
   input wire logic cpu_stall
);
   logic [8:0] last_lo_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         last_lo_ff <= 9'h000;
      else if (flash_rd)
         last_lo_ff <= flash_addr[8:0];
   end
   sequence s_fetch;
      flash_rd ##2 flash_rd;
   endsequence
   sequence s_start;
      $rose(cpu_stall);
   endsequence
   property p_ctrl_hi;
      sfr_req.addr == 8'hCE |=> sfr_rdata[7:5] == 3'b000;
   endproperty
   property p_rd_stall;
      flash_rd |-> cpu_stall;
   endproperty
   property p_rd_gap;
      flash_rd |=> !flash_rd;
   endproperty
   property p_addr_step;
      s_fetch |-> flash_addr == $past(flash_addr, 2) + 15'h0001;
   endproperty
   property p_stall_hold;
      flash_rd |=> cpu_stall;
   endproperty
   property p_start_rd;
      s_start |-> flash_rd;
   endproperty
   property p_base;
      s_start |-> flash_addr[8:0] == 9'h000;
   endproperty
   property p_sector_end;
      $fell(cpu_stall) |-> last_lo_ff == 9'h1FF;
   endproperty
   a_ctrl_hi: assert property (p_ctrl_hi)
      else $error("control upper bits not zero");
   a_rd_stall: assert property (p_rd_stall)
      else $error("flash read without stall");
   a_rd_gap: assert property (p_rd_gap)
      else $error("flash reads too close");
   a_addr_step: assert property (p_addr_step)
      else $error("flash address not ascending");
   a_stall_hold: assert property (p_stall_hold)
      else $error("stall dropped before fold");
   a_start_rd: assert property (p_start_rd)
      else $error("scan start without read");
   a_base: assert property (p_base)
      else $error("scan base not sector aligned");
   a_sector_end: assert property (p_sector_end)
      else $error("scan ended mid sector");
endmodule : crc_unit_sva
bind crc_unit crc_unit_sva crc_unit_sva_inst (.clk, .reset_n, .sfr_req,
   .sfr_rdata, .flash_rd, .flash_addr, .flash_rdata, .cpu_stall);

// file: tb/crc_unit_tb_top.sv
`timescale 1ns/100ps
module crc_unit_tb_top;
   logic clk;
   logic reset_n;
   crc_unit_pkg::sfr_req_t sfr_req;
   logic [7:0] sfr_rdata;
   logic flash_rd;
   logic [14:0] flash_addr;
   logic [7:0] flash_rdata;
   logic cpu_stall;
   int fail_count;
   int compares;
   int rd_count;
   crc_unit crc_unit_inst (.clk, .reset_n, .sfr_req, .sfr_rdata, .flash_rd,
      .flash_addr, .flash_rdata, .cpu_stall);
   flash_model flash_model_inst (.clk, .flash_rd, .flash_addr, .flash_rdata);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (flash_rd === 1'b1)
         rd_count++;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_req = '{1'b1, 1'b0, a, d};
      @(negedge clk);
      sfr_req.wr = 1'b0;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      sfr_req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk);
      sfr_req.rd = 1'b0;
      check({24'h0, sfr_rdata}, {24'h0, e});
   endtask : rchk
   // four port reads from the current pointer, low byte first
   task automatic rchk32(input logic [31:0] e);
      for (int i = 0; i < 4; i++)
         rchk(8'hDE, e[8*i +: 8]);
   endtask : rchk32
   function automatic logic [31:0] upd(input logic [31:0] c,
      input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++)
         r = (r >> 1) ^ (r[0] ? 32'hEDB88320 : 32'h0);
      return r;
   endfunction : upd
   //////////////////////////////////////////////////////////////////////
   task automatic test_crc16;
      wr(8'hCE, 8'h14);
      wr(8'hCE, 8'hFC);
      wr(8'hDD, 8'hAA);
      wr(8'hDD, 8'hBB);
      wr(8'hDD, 8'hCC);
      rchk(8'hDD, 8'hCC);
      rchk32(32'h6CF66CF6);
      rchk(8'hCE, 8'h14);
      $display("test_crc16 done");
   endtask : test_crc16
   task automatic test_crc32;
      wr(8'hCE, 8'h0C);
      wr(8'hDD, 8'h63);
      rchk32(32'hF9462090);
      rchk(8'hDE, 8'h90);
      wr(8'hDE, 8'h55);
      wr(8'hCE, 8'h00);
      rchk32(32'hF9465590);
      wr(8'hCE, 8'h08);
      rchk32(32'h0);
      $display("test_crc32 done");
   endtask : test_crc32
   task automatic test_scan;
      logic [31:0] e;
      e = 32'hFFFFFFFF;
      for (int a = 30 * 512; a < 32 * 512; a++)
         e = upd(e, a[7:0] ^ a[14:7]);
      wr(8'hCE, 8'h0C);
      wr(8'hD2, 8'h1E);
      wr(8'hD2, 8'h9E);
      wr(8'hD3, 8'h02);
      rchk(8'hD3, 8'h02);
      rchk(8'hD2, 8'hDE);
      rd_count = 0;
      wr(8'hCE, 8'h00);
      check({31'h0, cpu_stall}, 32'h1);
      wr(8'hDD, 8'h12);
      for (int n = 0; n < 3000 && cpu_stall !== 1'b0; n++)
         @(negedge clk);
      check(rd_count, 32'd1024);
      wr(8'hD2, 8'h1E);
      rchk32(e);
      $display("test_scan done");
   endtask : test_scan
   task automatic end_sim;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   //////////////////////////////////////////////////////////////////////
   initial begin
      #(40 * 6000);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim;
   end
   initial begin
      sfr_req = '0;
      reset_n = 1'b0;
      fail_count = 0;
      compares = 0;
      rd_count = 0;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      test_crc16;
      test_crc32;
      test_scan;
      end_sim;
   end
endmodule : crc_unit_tb_top
